// [isr_clip.sv]
// Clips a raw impedance sample into the programmed range limits
`timescale 1ns/100ps
`default_nettype none
module isr_clip #(
   parameter int W = 16
) (
   input wire logic [W-1:0] raw_in,
   input wire logic [W-1:0] lower_in,
   input wire logic [W-1:0] upper_in,
   output logic [W-1:0] clip_out
);
   // Saturate at either limit; limits are assumed ordered by the host
   always_comb begin
      if (raw_in > upper_in) begin
         clip_out = upper_in;
      end else if (raw_in < lower_in) begin
         clip_out = lower_in;
      end else begin
         clip_out = raw_in;
      end
   end
endmodule : isr_clip
`default_nettype wire

// [isr_consts.svh]
// Constants for the inductive sensor result readout block
`ifndef ISR_CONSTS_SVH
`define ISR_CONSTS_SVH
`define ISR_ADDR_W 8
`define ISR_ADDR_CFG 8'h04
`define ISR_ADDR_STATUS 8'h20
`define ISR_ADDR_PROX_LO 8'h21
`define ISR_ADDR_PROX_HI 8'h22
`define ISR_ADDR_RATE_LO 8'h23
`define ISR_ADDR_RATE_MID 8'h24
`define ISR_ADDR_RATE_HI 8'h25
`define ISR_RDY_BIT 6
`define ISR_RESP_DIV 3
`define ISR_RESP_RST 3'h0
`define ISR_BYTE_ZERO 8'h00
`define ISR_DRDY_IDLE 1'b1
`define ISR_DRDY_READY 1'b0
`define ISR_BYTE_0 7:0
`define ISR_BYTE_1 15:8
`define ISR_BYTE_2 23:16
`endif

// [isr_host_model.sv]
// Host model that reads result registers one byte per request
`timescale 1ns/100ps
`default_nettype none
module isr_host_model (
   input wire logic clk_sys_in,
   output var isr_pkg::isr_rd_req_t rd_req_out,
   input wire logic [7:0] rd_data_in
);
   import isr_pkg::*;
   initial rd_req_out = '0;
   // Request held one edge; address scrambled once released
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      rd_req_out <= '{rd_start: 1'b1, addr: a};
      @(posedge clk_sys_in);
      rd_req_out <= '{rd_start: 1'b0, addr: ~a};
      @(negedge clk_sys_in);
      d = rd_data_in;
   endtask : rd
endmodule : isr_host_model
`default_nettype wire

// [isr_pkg.sv]
// Types shared by the inductive sensor result readout block
package isr_pkg;
   typedef struct packed {
      logic [15:0] prox;
      logic [23:0] rate;
   } isr_result_t;
   typedef struct packed {
      logic rd_start;
      logic [7:0] addr;
   } isr_rd_req_t;
endpackage : isr_pkg

// [isr_readout.sv]
// Result snapshot and readback for the inductive sensor converter
`timescale 1ns/100ps
`default_nettype none
`include "isr_consts.svh"
module isr_readout (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire isr_pkg::isr_rd_req_t rd_req_in,
   output logic [7:0] rd_data_out,
   input wire logic conv_done_in,
   input wire isr_pkg::isr_result_t conv_in,
   input wire logic [15:0] impedance_range_lower_in,
   input wire logic [15:0] impedance_range_upper_in,
   input wire logic [2:0] resp_time_in,
   output logic [2:0] resp_time_out
);
   import isr_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Pending conversion and published snapshot
   isr_result_t pend_r, pend_nxt;
   isr_result_t snap_r, snap_nxt;
   logic drdy_n_r, drdy_n_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic [15:0] prox_clip;
   logic snap_now;
   logic [2:0] resp_r, resp_nxt;

   // Range clamp on the fresh impedance sample
   isr_clip #(.W(16)) u_clip (
      .raw_in(conv_in.prox),
      .lower_in(impedance_range_lower_in),
      .upper_in(impedance_range_upper_in),
      .clip_out(prox_clip)
   );

   ////////////////////////////////////////////////////////////////////
   // Response setting, handed on to the rate counter.
   // The counter divides the sensor clock by a third of this setting, so
   // the rate count arrives already as frequency/(setting/3). The copy is
   // registered so the counter never sees a half-written field; the cost
   // is one clock of lag after a configuration write.
   always_comb begin
      resp_nxt = resp_time_in;
   end

   // Response setting register
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         resp_r <= `ISR_RESP_RST;
      end else begin
         resp_r <= resp_nxt;
      end
   end

   assign resp_time_out = resp_r;

   ////////////////////////////////////////////////////////////////////
   // Snapshot trigger: a read that begins anywhere but the low byte
   // leaves the set alone, so a host polling status never tears it
   assign snap_now = rd_req_in.rd_start &&
      (rd_req_in.addr == `ISR_ADDR_PROX_LO);

   ////////////////////////////////////////////////////////////////////
   // Next-state: one atomic copy keeps bytes from one conversion
   always_comb begin
      pend_nxt = pend_r;
      snap_nxt = snap_r;
      drdy_n_nxt = drdy_n_r;
      // Each conversion overwrites the pending copy; a result that was
      // never fetched is dropped on purpose, the host wants the newest
      if (conv_done_in) begin
         pend_nxt.prox = prox_clip;
         pend_nxt.rate = conv_in.rate;
      end
      if (snap_now) begin
         snap_nxt = pend_r;
         drdy_n_nxt = `ISR_DRDY_IDLE;
      end
      // A new conversion outranks the clear of the ready flag
      if (conv_done_in) begin
         drdy_n_nxt = `ISR_DRDY_READY;
      end
   end

   // Read mux; 0x21 returns the bytes just captured
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_req_in.rd_start) begin
         unique case (rd_req_in.addr)
            `ISR_ADDR_STATUS: begin
               rd_data_nxt = `ISR_BYTE_ZERO;
               rd_data_nxt[`ISR_RDY_BIT] = drdy_n_r;
            end
            `ISR_ADDR_PROX_LO: rd_data_nxt = pend_r.prox[`ISR_BYTE_0];
            `ISR_ADDR_PROX_HI: rd_data_nxt = snap_r.prox[`ISR_BYTE_1];
            `ISR_ADDR_RATE_LO: rd_data_nxt = snap_r.rate[`ISR_BYTE_0];
            `ISR_ADDR_RATE_MID: rd_data_nxt = snap_r.rate[`ISR_BYTE_1];
            `ISR_ADDR_RATE_HI: rd_data_nxt = snap_r.rate[`ISR_BYTE_2];
            default: rd_data_nxt = `ISR_BYTE_ZERO;
         endcase
      end
   end

   // Result registers; the snapshot otherwise holds across conversions.
   // Cleared by reset only so early reads are defined, since the stored
   // result has no meaning before the first conversion.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_r <= '0;
         snap_r <= '0;
         drdy_n_r <= `ISR_DRDY_IDLE;
      end else begin
         pend_r <= pend_nxt;
         snap_r <= snap_nxt;
         drdy_n_r <= drdy_n_nxt;
      end
   end

   // Read data register; the byte stands until the next read begins
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_data_r <= `ISR_BYTE_ZERO;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data_out = rd_data_r;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_snap_only_lo: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) !snap_now |=> $stable(snap_r))
      else $error("snapshot changed without low-byte read");
   a_snap_capture: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) snap_now |=> snap_r == $past(pend_r))
      else $error("snapshot missed pending result");
   a_hi_byte_read: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) (rd_req_in.rd_start && !snap_now &&
      rd_req_in.addr == `ISR_ADDR_PROX_HI)
      |=> rd_data_out == snap_r.prox[`ISR_BYTE_1])
      else $error("wrong proximity high byte");
   a_rate_hi_read: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) (rd_req_in.rd_start &&
      rd_req_in.addr == `ISR_ADDR_RATE_HI)
      |=> rd_data_out == snap_r.rate[`ISR_BYTE_2])
      else $error("wrong rate high byte");
   a_rate_mid_read: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) (rd_req_in.rd_start &&
      rd_req_in.addr == `ISR_ADDR_RATE_MID)
      |=> rd_data_out == snap_r.rate[`ISR_BYTE_1])
      else $error("wrong rate middle byte");
   a_rate_lo_read: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) (rd_req_in.rd_start &&
      rd_req_in.addr == `ISR_ADDR_RATE_LO)
      |=> rd_data_out == snap_r.rate[`ISR_BYTE_0])
      else $error("wrong rate low byte");
   a_lo_byte_read: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) snap_now
      |=> rd_data_out == snap_r.prox[`ISR_BYTE_0])
      else $error("wrong proximity low byte");
   // Read data stands until the next read, whatever the converter does
   a_rd_data_hold: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) !rd_req_in.rd_start |=> $stable(rd_data_out))
      else $error("read data changed between reads");
   a_status_read: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) (rd_req_in.rd_start &&
      rd_req_in.addr == `ISR_ADDR_STATUS)
      |=> rd_data_out[`ISR_RDY_BIT] == $past(drdy_n_r))
      else $error("status ready bit wrong");
   a_ready_set: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) conv_done_in |=> !drdy_n_r)
      else $error("ready flag not raised");
   a_ready_clear: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) snap_now && !conv_done_in
      |=> drdy_n_r)
      else $error("ready flag not cleared");
   a_ready_hold: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) !conv_done_in && !snap_now
      |=> $stable(drdy_n_r))
      else $error("ready flag moved without cause");
   a_pend_rate: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) conv_done_in |=> pend_r.rate == $past(conv_in.rate))
      else $error("rate count not kept with its conversion");
   a_clip_range: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) conv_done_in &&
      impedance_range_lower_in <= impedance_range_upper_in
      |=> pend_r.prox <= $past(impedance_range_upper_in) &&
      pend_r.prox >= $past(impedance_range_lower_in))
      else $error("impedance not clipped");
   a_clip_low: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) conv_done_in &&
      conv_in.prox < impedance_range_lower_in &&
      impedance_range_lower_in <= impedance_range_upper_in
      |=> pend_r.prox == $past(impedance_range_lower_in))
      else $error("low impedance not held at lower limit");
   a_clip_high: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) conv_done_in &&
      conv_in.prox > impedance_range_upper_in &&
      impedance_range_lower_in <= impedance_range_upper_in
      |=> pend_r.prox == $past(impedance_range_upper_in))
      else $error("high impedance not held at upper limit");
   // Sampled reset gates the start too: on the release edge the register
   // is still held, so a check begun there would see a false lag
   a_resp_follow: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in) !sys_rst_in
      |=> resp_time_out == $past(resp_time_in))
      else $error("response setting not handed on");
endmodule : isr_readout
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the result readout block
`timescale 1ns/100ps
`default_nettype none
`include "isr_consts.svh"
module testbench;
   import isr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, done = 1'b0;
   isr_rd_req_t req;
   isr_result_t conv = '0;
   logic [7:0] rdat, d;
   logic [2:0] rt = 3'h5, rto;
   // Listed-style limit values, set before any conversion
   logic [15:0] lo = 16'h0100, hi = 16'hf000;
   int num_errors = 0, checks_done = 0;
   always #20 clk = ~clk;
   isr_readout dut (.clk_sys_in(clk), .sys_rst_in(rst), .rd_req_in(req),
      .rd_data_out(rdat), .conv_done_in(done), .conv_in(conv),
      .impedance_range_lower_in(lo), .impedance_range_upper_in(hi),
      .resp_time_in(rt), .resp_time_out(rto));
   isr_host_model host (.clk_sys_in(clk), .rd_req_out(req),
      .rd_data_in(rdat));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d);
      chk(d, e);
   endtask : rc
   // One-cycle conversion pulse from the sensor side
   task automatic cv(input logic [15:0] p, input logic [23:0] r);
      @(posedge clk);
      done <= 1'b1;
      conv <= '{prox: p, rate: r};
      @(posedge clk);
      done <= 1'b0;
   endtask : cv
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rc(`ISR_ADDR_STATUS, 8'h40);
      rc(`ISR_ADDR_PROX_HI, 8'h00);
      $display("test reset done");
   endtask : t_reset
   // Two conversions before a read: only the newer one is captured
   task automatic t_snap;
      cv(16'h1234, 24'habcdef);
      cv(16'h5678, 24'h123456);
      rc(`ISR_ADDR_STATUS, 8'h00);
      rc(`ISR_ADDR_PROX_LO, 8'h78);
      rc(`ISR_ADDR_PROX_HI, 8'h56);
      rc(`ISR_ADDR_RATE_LO, 8'h56);
      rc(`ISR_ADDR_RATE_MID, 8'h34);
      rc(`ISR_ADDR_RATE_HI, 8'h12);
      rc(`ISR_ADDR_STATUS, 8'h40);
      $display("test snapshot done");
   endtask : t_snap
   // A fresh conversion stays hidden until a set starts at the low byte
   task automatic t_hold;
      cv(16'h9abc, 24'h000000);
      rc(`ISR_ADDR_PROX_HI, 8'h56);
      rc(`ISR_ADDR_RATE_HI, 8'h12);
      rc(`ISR_ADDR_PROX_LO, 8'hbc);
      rc(`ISR_ADDR_RATE_HI, 8'h00);
      $display("test hold done");
   endtask : t_hold
   task automatic t_clip;
      cv(16'h0010, 24'h000001);
      rc(`ISR_ADDR_PROX_LO, 8'h00);
      rc(`ISR_ADDR_PROX_HI, 8'h01);
      cv(16'hffff, 24'h000002);
      rc(`ISR_ADDR_PROX_LO, 8'h00);
      rc(`ISR_ADDR_PROX_HI, 8'hf0);
      rc(8'h30, 8'h00);
      chk({5'h00, rto}, 8'h05);
      $display("test clip done");
   endtask : t_clip
   // Low-byte read in the very cycle a conversion lands: the read takes
   // the older result and the ready flag stays set for the newer one
   task automatic t_race;
      cv(16'h2468, 24'h0a0b0c);
      fork
         rc(`ISR_ADDR_PROX_LO, 8'h68);
         cv(16'h1357, 24'h0d0e0f);
      join
      rc(`ISR_ADDR_STATUS, 8'h00);
      rc(`ISR_ADDR_PROX_HI, 8'h24);
      rc(`ISR_ADDR_RATE_LO, 8'h0c);
      rc(`ISR_ADDR_PROX_LO, 8'h57);
      rc(`ISR_ADDR_PROX_HI, 8'h13);
      rc(`ISR_ADDR_RATE_LO, 8'h0f);
      repeat (3) @(negedge clk);
      chk(rdat, 8'h0f);
      rc(`ISR_ADDR_STATUS, 8'h40);
      $display("test race done");
   endtask : t_race
   // Reset in mid-run empties the result set and the ready flag
   task automatic t_rerst;
      cv(16'h0abc, 24'h000003);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc(`ISR_ADDR_STATUS, 8'h40);
      rc(`ISR_ADDR_PROX_LO, 8'h00);
      rc(`ISR_ADDR_PROX_HI, 8'h00);
      rc(`ISR_ADDR_RATE_MID, 8'h00);
      @(posedge clk);
      rt <= 3'h6;
      repeat (2) @(negedge clk);
      chk({5'h00, rto}, 8'h06);
      $display("test mid reset done");
   endtask : t_rerst
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_snap;
      t_hold;
      t_clip;
      t_race;
      t_rerst;
      wrap_up;
   end
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      wrap_up;
   end
endmodule : testbench
`default_nettype wire
